// file: mcmc_core.sv
// core: fetch sequencing, program map decode, data memory access, clock enables
`timescale 1ns/1ps
module mcmc_core import mcmc_pkg::*; (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // instruction fetch
  input wire logic fetch_step,
  input wire logic jump_valid,
  input wire mcmc_paddr_t jump_addr,
  input wire logic irq_take,
  output mcmc_paddr_t fetch_addr,
  output mcmc_region_t fetch_region,
  output logic fetch_fault,
  // table fetch
  input wire logic tbl_req,
  input wire mcmc_paddr_t tbl_addr,
  output mcmc_region_t tbl_region,
  output logic tbl_fault,
  // data memory
  input wire mcmc_dm_req_t dm_req,
  output logic [7:0] dm_rd_data,
  output logic dm_rd_valid,
  output logic dm_err,
  output logic [7:0] stack_ptr,
  // clock mode and timer-3 control
  input wire logic clkmd_wr,
  input wire logic [7:0] clkmd_wdata,
  input wire logic timer3_control_register_wr,
  input wire logic [7:0] timer3_control_register_wdata,
  input wire logic clk_conflict_clr,
  output logic [7:0] clkmd_q,
  output logic [7:0] timer3_control_register_q,
  output logic hrc_en,
  output logic lrc_en,
  output logic ulrc_en,
  output mcmc_src_t sysclk_src,
  output mcmc_div_t sysclk_div,
  output logic clk_conflict
);

  typedef struct packed {
    mcmc_paddr_t pc;
    mcmc_region_t fetch_region;
    logic fetch_fault;
    mcmc_region_t tbl_region;
    logic tbl_fault;
    logic [7:0] sp;
    logic [7:0] rd_data;
    logic rd_valid;
    logic dm_err;
    logic [7:0] clkmd;
    logic [7:0] timer3_control_register;
    mcmc_src_t src;
    mcmc_div_t div;
    logic clk_conflict;
  } mcmc_core_state_t;

  localparam mcmc_core_state_t RESET_STATE = '{
    pc: RESET_VECTOR,
    fetch_region: REG_RESET_VEC,
    fetch_fault: 1'b0,
    tbl_region: REG_NONE,
    tbl_fault: 1'b0,
    sp: SP_RESET,
    rd_data: 8'h00,
    rd_valid: 1'b0,
    dm_err: 1'b0,
    clkmd: CLKMD_RESET,
    timer3_control_register: TIMER3_CONTROL_REGISTER_RESET,
    src: SRC_HRC,
    div: DIV_4,
    clk_conflict: 1'b0
  };

  mcmc_core_state_t s_reg;
  mcmc_core_state_t s_next;

  // memory port wiring
  logic wr_en;
  logic [6:0] wr_idx;
  logic [7:0] wr_mask;
  logic [7:0] wr_data;
  logic [6:0] ra_idx;
  logic [7:0] ra_data;
  logic [7:0] rb_data;
  logic [7:0] eff_addr;
  logic in_range;
  logic is_write;
  mcmc_clksel_t sel;
  logic old_off;

  mcmc_dmem u_dmem (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_mask(wr_mask),
    .wr_data(wr_data),
    .ra_idx(ra_idx),
    .ra_data(ra_data),
    .rb_idx(dm_req.addr[6:0]),
    .rb_data(rb_data)
  );

  // effective address of the current data request
  always_comb begin
    eff_addr = dm_req.addr;
    in_range = dm_req.addr < DM_BYTES;
    case (dm_req.op)
      DM_RD_IND, DM_WR_IND: begin
        // the addressed byte itself is the pointer
        eff_addr = rb_data;
        in_range = (dm_req.addr < DM_BYTES) && (rb_data < DM_BYTES);
      end
      DM_PUSH: begin
        eff_addr = s_reg.sp;
        in_range = s_reg.sp < DM_BYTES;
      end
      DM_POP: begin
        eff_addr = 8'(s_reg.sp - BYTE_ONE);
        in_range = (s_reg.sp != SP_RESET) && (s_reg.sp <= DM_BYTES);
      end
      DM_SET_SP: in_range = 1'b1;
      default: eff_addr = dm_req.addr;
    endcase
    ra_idx = eff_addr[6:0];
    is_write = (dm_req.op == DM_WR_BYTE) || (dm_req.op == DM_WR_BIT) ||
               (dm_req.op == DM_WR_IND) || (dm_req.op == DM_PUSH);
    wr_en = ce && !rst && dm_req.valid && is_write && in_range;
    wr_idx = eff_addr[6:0];
    if (dm_req.op == DM_WR_BIT) begin
      wr_mask = 8'(BYTE_ONE << dm_req.bit_sel);
      wr_data = {8{dm_req.wdata[0]}};
    end else begin
      wr_mask = 8'hff;
      wr_data = dm_req.wdata;
    end
  end

  // clock mode decode of the incoming write
  always_comb begin
    sel = mcmc_clk_decode(clkmd_wdata);
    // old source stopped in the same write that leaves it
    old_off = (s_reg.src == SRC_HRC) ? !clkmd_wdata[HRC_EN_BIT] : !clkmd_wdata[LRC_EN_BIT];
  end

  always_comb begin
    s_next = s_reg;
    if (ce) begin
      // fetch sequencing: interrupt beats jump beats step
      if (irq_take) begin
        s_next.pc = IRQ_VECTOR;
      end else if (jump_valid) begin
        s_next.pc = jump_addr;
      end else if (fetch_step) begin
        s_next.pc = s_reg.pc + PC_ONE;
      end
      s_next.fetch_region = mcmc_region_of(s_next.pc);
      s_next.fetch_fault = (s_next.fetch_region == REG_SYSTEM) ||
                           (s_next.fetch_region == REG_NONE);
      if (tbl_req) begin
        s_next.tbl_region = mcmc_region_of(tbl_addr);
        s_next.tbl_fault = (s_next.tbl_region == REG_SYSTEM) ||
                           (s_next.tbl_region == REG_NONE);
      end

      // data memory
      s_next.rd_valid = 1'b0;
      if (dm_req.valid) begin
        s_next.dm_err = !in_range;
        case (dm_req.op)
          DM_RD_BYTE, DM_RD_IND, DM_POP: begin
            s_next.rd_valid = 1'b1;
            s_next.rd_data = in_range ? ra_data : 8'h00;
            if (dm_req.op == DM_POP && in_range) begin
              s_next.sp = eff_addr;
            end
          end
          DM_RD_BIT: begin
            s_next.rd_valid = 1'b1;
            s_next.rd_data = {7'h00, in_range && ra_data[dm_req.bit_sel]};
          end
          DM_PUSH: begin
            if (in_range) begin
              s_next.sp = 8'(s_reg.sp + BYTE_ONE);
            end
          end
          DM_SET_SP: s_next.sp = dm_req.wdata;
          default: s_next.rd_valid = 1'b0;
        endcase
      end

      // clock mode write takes effect on the same edge
      if (clkmd_wr) begin
        s_next.clkmd = clkmd_wdata;
        if (sel.valid) begin
          s_next.src = sel.src;
          s_next.div = sel.div;
        end
      end
      if (timer3_control_register_wr) begin
        s_next.timer3_control_register = timer3_control_register_wdata;
      end

      // flag only: the device cannot undo a stop of the oscillator it runs on
      if (clk_conflict_clr) begin
        s_next.clk_conflict = 1'b0;
      end
      if (clkmd_wr && sel.valid && (sel.src != s_reg.src) && old_off) begin
        s_next.clk_conflict = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign fetch_addr = s_reg.pc;
  assign fetch_region = s_reg.fetch_region;
  assign fetch_fault = s_reg.fetch_fault;
  assign tbl_region = s_reg.tbl_region;
  assign tbl_fault = s_reg.tbl_fault;
  assign dm_rd_data = s_reg.rd_data;
  assign dm_rd_valid = s_reg.rd_valid;
  assign dm_err = s_reg.dm_err;
  assign stack_ptr = s_reg.sp;
  assign clkmd_q = s_reg.clkmd;
  assign timer3_control_register_q = s_reg.timer3_control_register;
  assign hrc_en = s_reg.clkmd[HRC_EN_BIT];
  assign lrc_en = s_reg.clkmd[LRC_EN_BIT];
  assign ulrc_en = s_reg.timer3_control_register[ULRC_EN_BIT];
  assign sysclk_src = s_reg.src;
  assign sysclk_div = s_reg.div;
  assign clk_conflict = s_reg.clk_conflict;

  // checks

  property p_reset_vec;
    @(posedge core_clk) disable iff (rst)
      $fell(rst) |-> (fetch_addr == RESET_VECTOR) && (fetch_region == REG_RESET_VEC);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("fetch not at reset vector");

  property p_irq_vec;
    @(posedge core_clk) disable iff (rst)
      (ce && irq_take) |=> (fetch_addr == IRQ_VECTOR) && (fetch_region == REG_IRQ_VEC);
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("interrupt entry missed");

  property p_pmem_range;
    @(posedge core_clk) disable iff (rst)
      (ce && tbl_req && (tbl_addr > SYS_LAST)) |=> tbl_fault && (tbl_region == REG_NONE);
  endproperty
  a_pmem_range: assert property (p_pmem_range) else $error("beyond 1.5K not faulted");

  property p_user_space;
    @(posedge core_clk) disable iff (rst)
      (ce && tbl_req && (tbl_addr != RESET_VECTOR) && (tbl_addr != IRQ_VECTOR) &&
       (tbl_addr <= USER_LAST)) |=> !tbl_fault && (tbl_region == REG_USER);
  endproperty
  a_user_space: assert property (p_user_space) else $error("user address misdecoded");

  property p_sys_space;
    @(posedge core_clk) disable iff (rst)
      (ce && tbl_req && (tbl_addr > USER_LAST) && (tbl_addr <= SYS_LAST))
        |=> tbl_fault && (tbl_region == REG_SYSTEM);
  endproperty
  a_sys_space: assert property (p_sys_space) else $error("system area not reserved");

  sequence s_byte_wr;
    ce && dm_req.valid && (dm_req.op == DM_WR_BYTE) && (dm_req.addr < DM_BYTES);
  endsequence
  sequence s_byte_rd_same;
    ce && dm_req.valid && (dm_req.op == DM_RD_BYTE) && (dm_req.addr == $past(dm_req.addr));
  endsequence
  property p_byte_rw;
    @(posedge core_clk) disable iff (rst)
      s_byte_wr ##1 s_byte_rd_same |=> dm_rd_valid && (dm_rd_data == $past(dm_req.wdata, 2));
  endproperty
  a_byte_rw: assert property (p_byte_rw) else $error("byte read-back mismatch");

  property p_push;
    @(posedge core_clk) disable iff (rst)
      (ce && dm_req.valid && (dm_req.op == DM_PUSH) && (stack_ptr < DM_BYTES))
        |=> (stack_ptr == 8'($past(stack_ptr) + BYTE_ONE)) && !dm_err;
  endproperty
  a_push: assert property (p_push) else $error("push did not advance stack");

  property p_indirect;
    @(posedge core_clk) disable iff (rst)
      (ce && dm_req.valid && (dm_req.op == DM_RD_IND) && (dm_req.addr < DM_BYTES))
        |=> (dm_err == ($past(rb_data) >= DM_BYTES)) && dm_rd_valid;
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect range wrong");

  property p_osc_bits;
    @(posedge core_clk) disable iff (rst)
      (ce && clkmd_wr) |=> (hrc_en == $past(clkmd_wdata[HRC_EN_BIT])) &&
                           (lrc_en == $past(clkmd_wdata[LRC_EN_BIT]));
  endproperty
  a_osc_bits: assert property (p_osc_bits) else $error("oscillator enable mismatch");

  property p_ulrc_hold;
    @(posedge core_clk) disable iff (rst)
      !(ce && timer3_control_register_wr) && !rst |=> $stable(ulrc_en);
  endproperty
  a_ulrc_hold: assert property (p_ulrc_hold) else $error("ultra-low enable changed");

  property p_clk_switch;
    @(posedge core_clk) disable iff (rst)
      (ce && clkmd_wr && sel.valid) |=> (sysclk_src == $past(sel.src)) &&
                                       (sysclk_div == $past(sel.div));
  endproperty
  a_clk_switch: assert property (p_clk_switch) else $error("clock not switched");

  property p_boot_osc;
    @(posedge core_clk) disable iff (rst)
      $fell(rst) |-> hrc_en && lrc_en && ulrc_en && (sysclk_src == SRC_HRC);
  endproperty
  a_boot_osc: assert property (p_boot_osc) else $error("oscillator off after boot");

endmodule : mcmc_core

// file: mcmc_pkg.sv
// package: program map, data memory and clock-mode constants for the core
// Functional notes
// - after any reset, instruction fetch starts at program address 0x000
// - a taken interrupt sends execution to program address 0x010
// - program memory is 1.5K words; the decoder covers the whole range
// - user code lives at 0x001..0x00F and 0x011..0x5EF only
// - addresses 0x5F0..0x5FF are system area, never user program space
// - data memory supports byte and single-bit reads and writes
// - stack lives in data memory behind a freely writable stack pointer
// - any data byte can be a pointer; indirect access reaches all 96 bytes
// - clock mode bit 4 enables the fast oscillator, bit 2 the slow one
// - ultra-low oscillator runs by default; timer-3 control bit 0 switches it
// - system clock is fast or slow oscillator, chosen with divider in clock mode
// - after boot all three internal oscillators are running
// - a clock mode write with a decodable select code switches the system clock right after the write; other codes keep it
package mcmc_pkg;

  // program memory map
  typedef logic [10:0] mcmc_paddr_t;
  localparam mcmc_paddr_t RESET_VECTOR = 11'h000;
  localparam mcmc_paddr_t IRQ_VECTOR = 11'h010;
  localparam mcmc_paddr_t USER_LAST = 11'h5ef;
  localparam mcmc_paddr_t SYS_LAST = 11'h5ff;
  localparam mcmc_paddr_t PC_ONE = 11'h001;

  // data memory
  localparam int DM_DEPTH = 96;
  localparam logic [7:0] DM_BYTES = 8'h60;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] SP_RESET = 8'h00;

  // clock mode and timer-3 control layout
  localparam int HRC_EN_BIT = 4;
  localparam int LRC_EN_BIT = 2;
  localparam int ULRC_EN_BIT = 0;
  localparam int CLKMD_SEL_MSB = 7;
  localparam int CLKMD_SEL_LSB = 5;
  localparam int CLKMD_SUB_BIT = 3;
  localparam logic [7:0] CLKMD_RESET = 8'h14;
  localparam logic [7:0] TIMER3_CONTROL_REGISTER_RESET = 8'h01;
  localparam logic [3:0] CSEL_HRC_4 = 4'h0;
  localparam logic [3:0] CSEL_HRC_16 = 4'h1;
  localparam logic [3:0] CSEL_HRC_8A = 4'h2;
  localparam logic [3:0] CSEL_HRC_8B = 4'h3;
  localparam logic [3:0] CSEL_HRC_32 = 4'h7;
  localparam logic [3:0] CSEL_LRC_1 = 4'he;

  typedef enum logic [2:0] {REG_RESET_VEC, REG_USER, REG_IRQ_VEC, REG_SYSTEM, REG_NONE}
    mcmc_region_t;
  typedef enum logic [3:0] {DM_RD_BYTE, DM_WR_BYTE, DM_RD_BIT, DM_WR_BIT, DM_RD_IND,
    DM_WR_IND, DM_PUSH, DM_POP, DM_SET_SP} mcmc_dm_op_t;
  typedef enum logic {SRC_HRC, SRC_LRC} mcmc_src_t;
  typedef enum logic [2:0] {DIV_1, DIV_4, DIV_8, DIV_16, DIV_32} mcmc_div_t;

  typedef struct packed {
    logic valid;
    mcmc_dm_op_t op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } mcmc_dm_req_t;

  typedef struct packed {
    logic valid;
    mcmc_src_t src;
    mcmc_div_t div;
  } mcmc_clksel_t;

  function automatic mcmc_region_t mcmc_region_of(input mcmc_paddr_t a);
    if (a == RESET_VECTOR) return REG_RESET_VEC;
    else if (a == IRQ_VECTOR) return REG_IRQ_VEC;
    else if (a <= USER_LAST) return REG_USER;
    else if (a <= SYS_LAST) return REG_SYSTEM;
    else return REG_NONE;
  endfunction : mcmc_region_of

  function automatic mcmc_clksel_t mcmc_clk_decode(input logic [7:0] v);
    mcmc_clksel_t r;
    r.valid = 1'b1;
    r.src = SRC_HRC;
    r.div = DIV_4;
    case ({v[CLKMD_SEL_MSB:CLKMD_SEL_LSB], v[CLKMD_SUB_BIT]})
      CSEL_HRC_4: r.div = DIV_4;
      CSEL_HRC_16: r.div = DIV_16;
      CSEL_HRC_8A: r.div = DIV_8;
      CSEL_HRC_8B: r.div = DIV_8;
      CSEL_HRC_32: r.div = DIV_32;
      CSEL_LRC_1: begin
        r.src = SRC_LRC;
        r.div = DIV_1;
      end
      default: r.valid = 1'b0;
    endcase
    return r;
  endfunction : mcmc_clk_decode

endpackage : mcmc_pkg

// file: mcmc_dmem.sv
// data memory: 96 bytes of flip-flops, masked write, two read ports
`timescale 1ns/1ps
module mcmc_dmem import mcmc_pkg::*; (
  // clock and control
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // write port
  input wire logic wr_en,
  input wire logic [6:0] wr_idx,
  input wire logic [7:0] wr_mask,
  input wire logic [7:0] wr_data,
  // read ports
  input wire logic [6:0] ra_idx,
  output logic [7:0] ra_data,
  input wire logic [6:0] rb_idx,
  output logic [7:0] rb_data
);

  typedef struct packed {
    logic [DM_DEPTH-1:0][7:0] mem;
  } mcmc_dmem_state_t;

  mcmc_dmem_state_t s_reg;
  mcmc_dmem_state_t s_next;

  // indexes past the last byte read as zero
  assign ra_data = (ra_idx < DM_BYTES[6:0]) ? s_reg.mem[ra_idx] : 8'h00;
  assign rb_data = (rb_idx < DM_BYTES[6:0]) ? s_reg.mem[rb_idx] : 8'h00;

  always_comb begin
    s_next = s_reg;
    if (ce && wr_en && (wr_idx < DM_BYTES[6:0])) begin
      // mask lets one bit change without touching its neighbours
      s_next.mem[wr_idx] = (s_reg.mem[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : mcmc_dmem

// file: mcmc_tb.sv
// self-checking bench for the core: fetch map, data memory, clock enables
`timescale 1ns/1ps
module testbench;
  import mcmc_pkg::*;

  // clock, reset, enable
  logic core_clk;
  logic rst;
  logic ce;
  // fetch and table
  logic fetch_step;
  logic jump_valid;
  mcmc_paddr_t jump_addr;
  logic irq_take;
  mcmc_paddr_t fetch_addr;
  mcmc_region_t fetch_region;
  logic fetch_fault;
  logic tbl_req;
  mcmc_paddr_t tbl_addr;
  mcmc_region_t tbl_region;
  logic tbl_fault;
  // data memory
  mcmc_dm_req_t dm_req;
  logic [7:0] dm_rd_data;
  logic dm_rd_valid;
  logic dm_err;
  logic [7:0] stack_ptr;
  // clock mode
  logic clkmd_wr;
  logic [7:0] clkmd_wdata;
  logic timer3_control_register_wr;
  logic [7:0] timer3_control_register_wdata;
  logic clk_conflict_clr;
  logic [7:0] clkmd_q;
  logic [7:0] timer3_control_register_q;
  logic hrc_en;
  logic lrc_en;
  logic ulrc_en;
  mcmc_src_t sysclk_src;
  mcmc_div_t sysclk_div;
  logic clk_conflict;

  int fails = 0;
  int checked = 0;
  int cycles = 0;

  mcmc_core u_mcmc_core (
    .core_clk(core_clk), .rst(rst), .ce(ce),
    .fetch_step(fetch_step), .jump_valid(jump_valid), .jump_addr(jump_addr),
    .irq_take(irq_take), .fetch_addr(fetch_addr), .fetch_region(fetch_region),
    .fetch_fault(fetch_fault), .tbl_req(tbl_req), .tbl_addr(tbl_addr),
    .tbl_region(tbl_region), .tbl_fault(tbl_fault), .dm_req(dm_req),
    .dm_rd_data(dm_rd_data), .dm_rd_valid(dm_rd_valid), .dm_err(dm_err),
    .stack_ptr(stack_ptr), .clkmd_wr(clkmd_wr), .clkmd_wdata(clkmd_wdata),
    .timer3_control_register_wr(timer3_control_register_wr), .timer3_control_register_wdata(timer3_control_register_wdata), .clk_conflict_clr(clk_conflict_clr),
    .clkmd_q(clkmd_q), .timer3_control_register_q(timer3_control_register_q), .hrc_en(hrc_en), .lrc_en(lrc_en),
    .ulrc_en(ulrc_en), .sysclk_src(sysclk_src), .sysclk_div(sysclk_div),
    .clk_conflict(clk_conflict)
  );

  always #5 core_clk = ~core_clk;

  task automatic wrap_up;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // a hang is a failure, not a silent stall
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // each task drives one request cycle, releases it, and lands just after the answer edge
  task automatic fetch(input logic stp, input logic jv, input mcmc_paddr_t ja,
                       input logic irq);
    @(posedge core_clk);
    fetch_step <= stp;
    jump_valid <= jv;
    jump_addr <= ja;
    irq_take <= irq;
    @(posedge core_clk);
    fetch_step <= 1'b0;
    jump_valid <= 1'b0;
    irq_take <= 1'b0;
    #1;
  endtask : fetch

  task automatic tbl(input mcmc_paddr_t a, input mcmc_region_t r, input logic f);
    @(posedge core_clk);
    tbl_req <= 1'b1;
    tbl_addr <= a;
    @(posedge core_clk);
    tbl_req <= 1'b0;
    #1;
    chk(tbl_region, r);
    chk(tbl_fault, f);
  endtask : tbl

  task automatic dm(input mcmc_dm_op_t op, input logic [7:0] a, input logic [2:0] b,
                    input logic [7:0] wd);
    @(posedge core_clk);
    dm_req <= '{valid: 1'b1, op: op, addr: a, bit_sel: b, wdata: wd};
    @(posedge core_clk);
    dm_req.valid <= 1'b0;
    #1;
  endtask : dm

  // read paths: valid pulse and data seen in the one cycle they stand
  task automatic rd(input mcmc_dm_op_t op, input logic [7:0] a, input logic [2:0] b,
                    input logic [7:0] exp);
    dm(op, a, b, 8'h00);
    chk(dm_rd_valid, 1'b1);
    chk(dm_rd_data, exp);
    chk(dm_err, 1'b0);
  endtask : rd

  task automatic cm(input logic [7:0] v);
    @(posedge core_clk);
    clkmd_wr <= 1'b1;
    clkmd_wdata <= v;
    @(posedge core_clk);
    clkmd_wr <= 1'b0;
    #1;
    chk(clkmd_q, v);
  endtask : cm

  task automatic t3(input logic [7:0] v);
    @(posedge core_clk);
    timer3_control_register_wr <= 1'b1;
    timer3_control_register_wdata <= v;
    @(posedge core_clk);
    timer3_control_register_wr <= 1'b0;
    #1;
  endtask : t3

  task automatic boot_state;
    chk(fetch_addr, RESET_VECTOR);
    chk(fetch_region, REG_RESET_VEC);
    chk({hrc_en, lrc_en, ulrc_en}, 3'h7);
    chk(clkmd_q, CLKMD_RESET);
    chk(timer3_control_register_q, TIMER3_CONTROL_REGISTER_RESET);
    chk({clk_conflict, dm_err, stack_ptr}, {1'b0, 1'b0, SP_RESET});
  endtask : boot_state

  // slow mode entered with the fast source still on, so no conflict is raised
  logic [7:0] modes [5] = '{8'h14, 8'h3c, 8'h1c, 8'h7c, 8'hf4};
  mcmc_div_t divs [5] = '{DIV_4, DIV_8, DIV_16, DIV_32, DIV_1};

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    fetch_step = 1'b0;
    jump_valid = 1'b0;
    jump_addr = 11'h000;
    irq_take = 1'b0;
    tbl_req = 1'b0;
    tbl_addr = 11'h000;
    dm_req = '0;
    clkmd_wr = 1'b0;
    clkmd_wdata = 8'h00;
    timer3_control_register_wr = 1'b0;
    timer3_control_register_wdata = 8'h00;
    clk_conflict_clr = 1'b0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    boot_state();
    // program map: step, both user ranges, vector priority, system area
    fetch(1'b1, 1'b0, 11'h000, 1'b0);
    chk({fetch_addr, fetch_region}, {PC_ONE, REG_USER});
    fetch(1'b1, 1'b1, 11'h00f, 1'b1);
    chk({fetch_addr, fetch_region}, {IRQ_VECTOR, REG_IRQ_VEC});
    fetch(1'b1, 1'b0, 11'h000, 1'b0);
    chk({fetch_addr, fetch_region, fetch_fault}, {11'h011, REG_USER, 1'b0});
    fetch(1'b0, 1'b1, 11'h5ef, 1'b0);
    chk({fetch_region, fetch_fault}, {REG_USER, 1'b0});
    fetch(1'b1, 1'b0, 11'h000, 1'b0);
    chk({fetch_addr, fetch_region, fetch_fault}, {11'h5f0, REG_SYSTEM, 1'b1});
    fetch(1'b0, 1'b1, 11'h600, 1'b0);
    chk({fetch_addr, fetch_region, fetch_fault}, {11'h600, REG_NONE, 1'b1});
    tbl(11'h5ff, REG_SYSTEM, 1'b1);
    tbl(11'h5ef, REG_USER, 1'b0);
    tbl(11'h00f, REG_USER, 1'b0);
    tbl(11'h010, REG_IRQ_VEC, 1'b0);
    tbl(11'h600, REG_NONE, 1'b1);
    tbl(11'h000, REG_RESET_VEC, 1'b0);
    // data memory: top byte, refusal past the end, bits, pointer, stack
    dm(DM_WR_BYTE, 8'h5f, 3'h0, 8'haa);
    rd(DM_RD_BYTE, 8'h5f, 3'h0, 8'haa);
    dm(DM_RD_BYTE, DM_BYTES, 3'h0, 8'h00);
    chk(dm_err, 1'b1);
    dm(DM_WR_BIT, 8'h03, 3'h7, 8'h01);
    rd(DM_RD_BYTE, 8'h03, 3'h0, 8'h80);
    rd(DM_RD_BIT, 8'h03, 3'h7, 8'h01);
    rd(DM_RD_BIT, 8'h03, 3'h6, 8'h00);
    dm(DM_WR_BYTE, 8'h0a, 3'h0, 8'h5f);
    rd(DM_RD_IND, 8'h0a, 3'h0, 8'haa);
    dm(DM_WR_IND, 8'h0a, 3'h0, 8'h33);
    rd(DM_RD_BYTE, 8'h5f, 3'h0, 8'h33);
    dm(DM_POP, 8'h00, 3'h0, 8'h00);
    chk({dm_err, stack_ptr}, {1'b1, SP_RESET});
    dm(DM_SET_SP, 8'h00, 3'h0, 8'h20);
    dm(DM_PUSH, 8'h00, 3'h0, 8'h55);
    chk({dm_err, stack_ptr}, {1'b0, 8'h21});
    rd(DM_RD_BYTE, 8'h20, 3'h0, 8'h55);
    rd(DM_POP, 8'h00, 3'h0, 8'h55);
    chk(stack_ptr, 8'h20);
    // enable low must freeze the fetch pointer and block memory writes
    @(posedge core_clk);
    ce <= 1'b0;
    fetch(1'b0, 1'b1, 11'h040, 1'b1);
    dm(DM_WR_BYTE, 8'h20, 3'h0, 8'h99);
    chk(fetch_addr, 11'h600);
    @(posedge core_clk);
    ce <= 1'b1;
    rd(DM_RD_BYTE, 8'h20, 3'h0, 8'h55);
    // write then read back to back, no idle cycle between
    @(posedge core_clk);
    dm_req <= '{valid: 1'b1, op: DM_WR_BYTE, addr: 8'h05, bit_sel: 3'h0, wdata: 8'ha5};
    @(posedge core_clk);
    dm_req <= '{valid: 1'b1, op: DM_RD_BYTE, addr: 8'h05, bit_sel: 3'h0, wdata: 8'h00};
    @(posedge core_clk);
    dm_req.valid <= 1'b0;
    #1;
    chk({dm_rd_valid, dm_rd_data}, {1'b1, 8'ha5});
    // every documented mode except CSEL_HRC_8A, each taking hold at the next edge
    for (int i = 0; i < 5; i++) begin
      cm(modes[i]);
      chk(sysclk_div, divs[i]);
      chk(sysclk_src, (i == 4) ? SRC_LRC : SRC_HRC);
      chk({hrc_en, lrc_en}, {modes[i][4], 1'b1});
    end
    cm(8'h3c);
    cm(8'h38);
    chk({hrc_en, lrc_en}, 2'h2);
    chk(clk_conflict, 1'b0);
    // legal handover to the slow source, then a forbidden one from fast
    cm(8'hf4);
    cm(8'he4);
    chk({sysclk_src, hrc_en, clk_conflict}, {SRC_LRC, 1'b0, 1'b0});
    cm(8'h14);
    cm(8'he0);
    chk(clk_conflict, 1'b1);
    @(posedge core_clk);
    clk_conflict_clr <= 1'b1;
    @(posedge core_clk);
    clk_conflict_clr <= 1'b0;
    #1;
    chk(clk_conflict, 1'b0);
    t3(8'h00);
    chk({ulrc_en, hrc_en}, 2'h0);
    t3(8'h01);
    chk(ulrc_en, 1'b1);
    t3(8'h00);
    chk(timer3_control_register_q, 8'h00);
    // a new conflict in the clearing cycle must win over the clear
    @(posedge core_clk);
    clkmd_wr <= 1'b1;
    clkmd_wdata <= 8'h30;
    clk_conflict_clr <= 1'b1;
    @(posedge core_clk);
    clkmd_wr <= 1'b0;
    clk_conflict_clr <= 1'b0;
    #1;
    chk({clk_conflict, sysclk_src}, {1'b1, SRC_HRC});
    // second reset mid-run restores vector and oscillators
    fetch(1'b0, 1'b1, 11'h123, 1'b0);
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    boot_state();
    wrap_up();
  end

endmodule : testbench
